// file: logic/bpgs_sequencer.sv
// bracket pulse gate sequencer: shapes cathode gate and plate bias window
`timescale 1ns/10ps
// What this block does
// - bracket mode: plate off outside gate window
// - plate on at least 35 ns first
// - plate held 1 us after gate
// - repetition capped 6.25 khz bracket, 1 mhz otherwise
// - bracket adds 10 ns trigger latency
// - bracket delay clamped to 35 ns minimum
// - trigger reference about 12 ns after trigger
// - no bracket with filmless third generation tube
// - bracket only via host enable setting
// - window derived from gate delay, width
module bpgs_sequencer (
  input  wire logic               clk,        // 200 mhz clock
  input  wire logic               rst_b,      // async reset, active low
  input  wire logic               clk_en,     // freezes all state when low
  input  wire logic               trigger_in, // external trigger level
  input  wire bpgs_pkg::bpgs_cfg_s cfg,       // mode and gate timing
  output bpgs_pkg::bpgs_drv_s     drv,        // bias driver outputs
  output logic                    bracket_active // bracket mode in force
);

  // ==========================================================================
  // declarations
  bpgs_pkg::bpgs_state_e state_reg;           // sequencer state
  bpgs_pkg::bpgs_cnt_t   cnt_reg;             // phase counter
  bpgs_pkg::bpgs_cnt_t   rate_reg;            // cycles since trigger
  bpgs_pkg::bpgs_cnt_t   period_lim;          // least trigger spacing
  bpgs_pkg::bpgs_cnt_t   delay_eff;           // effective gate delay
  bpgs_pkg::bpgs_cnt_t   width_eff;           // effective gate width
  logic [7:0]            tref_cnt_reg;        // reference delay/width
  logic                  trig_d_reg;          // trigger last cycle
  logic                  trig_edge;           // trigger rising edge
  logic                  brk_reg;             // mode latched per shot
  logic                  brk_mode;            // bracket allowed now
  logic                  cath_next;           // cathode gate next value
  logic                  plate_next;          // plate bias next value
  logic                  cath_reg;            // cathode gate flop
  logic                  plate_reg;           // plate bias flop
  logic                  tref_reg;            // trigger reference flop

  // ==========================================================================
  // helpers
  // truncate an int constant to counter width
  function automatic bpgs_pkg::bpgs_cnt_t to_cnt(input int v);
    to_cnt = v[bpgs_pkg::CNT_W-1:0];
  endfunction : to_cnt

  // ==========================================================================
  // mode decode
  // bracket only when host asks and tube is not filmless
  assign brk_mode = cfg.bracket_enable &
                    ~cfg.third_generation_filmless_intensifier;
  assign bracket_active = brk_reg;

  // one flop per driver line, gathered into the carrier
  assign drv = '{photocathode_gate:            cath_reg,
                 multiplier_plate_bias_enable: plate_reg,
                 trigger_reference_output:     tref_reg};

  // repetition spacing by mode
  assign period_lim = brk_reg ? to_cnt(bpgs_pkg::BRK_PERIOD_CYC)
                              : to_cnt(bpgs_pkg::STD_PERIOD_CYC);

  // delay from programmed value plus bracket latency, clamped
  always_comb begin
    delay_eff = cfg.gate_delay;
    // zero delay would underflow the down counter; keep one cycle
    if (delay_eff == '0) begin
      delay_eff = to_cnt(1);
    end
    if (brk_mode) begin
      delay_eff = cfg.gate_delay + to_cnt(bpgs_pkg::EXTRA_LAT_CYC);
      if (delay_eff < to_cnt(bpgs_pkg::MIN_DELAY_CYC)) begin
        delay_eff = to_cnt(bpgs_pkg::MIN_DELAY_CYC);
      end
    end
    // zero width would underflow the down counter; keep one cycle
    width_eff = (cfg.gate_width == '0) ? to_cnt(1) : cfg.gate_width;
  end

  assign trig_edge = trigger_in & ~trig_d_reg;

  // ==========================================================================
  // trigger edge detector
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      trig_d_reg <= 1'b0;
    end else if (clk_en) begin
      trig_d_reg <= trigger_in;
    end
  end

  // ==========================================================================
  // repetition counter, counts from each accepted trigger
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rate_reg <= '1;
    end else if (clk_en) begin
      if (state_reg == bpgs_pkg::BPGS_IDLE && trig_edge) begin
        rate_reg <= '0;
      end else if (rate_reg != '1) begin
        rate_reg <= rate_reg + to_cnt(1);
      end
    end
  end

  // ==========================================================================
  // main sequencer
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_reg <= bpgs_pkg::BPGS_IDLE;
      cnt_reg   <= '0;
      brk_reg   <= 1'b0;
    end else if (clk_en) begin
      unique case (state_reg)
        bpgs_pkg::BPGS_IDLE: begin
          brk_reg <= brk_mode;              // mode changes between shots
          if (trig_edge) begin
            brk_reg   <= brk_mode;
            state_reg <= bpgs_pkg::BPGS_DELAY;
            cnt_reg   <= delay_eff - to_cnt(1);
          end
        end
        bpgs_pkg::BPGS_DELAY: begin
          if (cnt_reg == '0) begin
            state_reg <= bpgs_pkg::BPGS_GATE;
            cnt_reg   <= width_eff - to_cnt(1);
          end else begin
            cnt_reg <= cnt_reg - to_cnt(1);
          end
        end
        bpgs_pkg::BPGS_GATE: begin
          if (cnt_reg == '0) begin
            // tail only matters in bracket mode
            state_reg <= brk_reg ? bpgs_pkg::BPGS_TAIL
                                 : bpgs_pkg::BPGS_HOLD;
            cnt_reg   <= to_cnt(bpgs_pkg::PLATE_TAIL_CYC - 1);
          end else begin
            cnt_reg <= cnt_reg - to_cnt(1);
          end
        end
        bpgs_pkg::BPGS_TAIL: begin
          if (cnt_reg == '0) begin
            state_reg <= bpgs_pkg::BPGS_HOLD;
          end else begin
            cnt_reg <= cnt_reg - to_cnt(1);
          end
        end
        bpgs_pkg::BPGS_HOLD: begin
          // wait out the repetition period before rearming
          if (rate_reg >= period_lim - to_cnt(1)) begin
            state_reg <= bpgs_pkg::BPGS_IDLE;
          end
        end
        default: begin
          state_reg <= bpgs_pkg::BPGS_IDLE;
        end
      endcase
    end
  end

  // ==========================================================================
  // output decode, registered below
  always_comb begin
    cath_next  = 1'b0;
    plate_next = 1'b1;
    unique case (state_reg)
      bpgs_pkg::BPGS_IDLE: begin
        cath_next  = 1'b0;
        // shortest bracket delay: plate must rise on the taking edge
        plate_next = ~brk_mode | (trig_edge &&
          (delay_eff <= to_cnt(bpgs_pkg::PLATE_LEAD_CYC)));
      end
      bpgs_pkg::BPGS_DELAY: begin
        cath_next = (cnt_reg == '0);
        // plate rises lead cycles before the cathode gate
        plate_next = ~brk_reg |
          (cnt_reg <= to_cnt(bpgs_pkg::PLATE_LEAD_CYC));
      end
      bpgs_pkg::BPGS_GATE: begin
        cath_next  = (cnt_reg != '0);
        plate_next = 1'b1;
      end
      bpgs_pkg::BPGS_TAIL: begin
        cath_next  = 1'b0;
        plate_next = 1'b1;
      end
      bpgs_pkg::BPGS_HOLD: begin
        cath_next  = 1'b0;
        plate_next = ~brk_reg;
      end
      default: begin
        cath_next  = 1'b0;
        plate_next = 1'b1;
      end
    endcase
  end

  // ==========================================================================
  // driver output flops
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cath_reg  <= 1'b0;
      plate_reg <= 1'b1;
    end else if (clk_en) begin
      cath_reg  <= cath_next;
      plate_reg <= plate_next;
    end
  end

  // ==========================================================================
  // trigger reference pulse: delay then fixed width
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      tref_cnt_reg <= 8'h00;
      tref_reg     <= 1'b0;
    end else if (clk_en) begin
      if (state_reg == bpgs_pkg::BPGS_IDLE && trig_edge) begin
        tref_cnt_reg <= 8'h01;
      end else if (tref_cnt_reg != 8'h00) begin
        // last count of the pulse ends it, so it is exactly tref_w wide
        tref_cnt_reg <= (tref_cnt_reg == 8'(bpgs_pkg::TREF_DELAY_CYC +
                         bpgs_pkg::TREF_W - 1)) ? 8'h00
                                               : tref_cnt_reg + 8'h01;
      end
      // in every mode reference lags trigger by about 12 ns
      tref_reg <= (tref_cnt_reg >= 8'(bpgs_pkg::TREF_DELAY_CYC)) &&
                  (tref_cnt_reg != 8'h00);
    end
  end

endmodule : bpgs_sequencer

// file: include/bpgs_pkg.sv
// package of constants and carrier types for the bracket pulse gate sequencer
package bpgs_pkg;

  // ==========================================================================
  // clock and timing figures
  localparam int CLK_PERIOD_PS    = 5000;     // 200 mhz clock period
  localparam int PLATE_LEAD_NS    = 35;       // plate on before cathode gate
  localparam int PLATE_TAIL_NS    = 1000;     // plate held after gate end
  localparam int EXTRA_LAT_NS     = 10;       // added trigger latency
  localparam int MIN_DELAY_NS     = 35;       // least delay in bracket mode
  localparam int TREF_DELAY_NS    = 12;       // trigger reference latency
  localparam int BRK_PERIOD_NS    = 160000;   // 1 / 6.25 khz
  localparam int STD_PERIOD_NS    = 1000;     // 1 / 1 mhz

  // least times round up, the reference latency rounds to nearest
  localparam int PLATE_LEAD_CYC =
    (PLATE_LEAD_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int PLATE_TAIL_CYC =
    (PLATE_TAIL_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int EXTRA_LAT_CYC =
    (EXTRA_LAT_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int MIN_DELAY_CYC =
    (MIN_DELAY_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int TREF_DELAY_CYC =
    (TREF_DELAY_NS * 1000 + CLK_PERIOD_PS / 2) / CLK_PERIOD_PS;
  localparam int BRK_PERIOD_CYC =
    (BRK_PERIOD_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int STD_PERIOD_CYC =
    (STD_PERIOD_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

  // ==========================================================================
  // widths
  localparam int CNT_W  = 24;                 // timing counter width
  localparam int TREF_W = 8;                  // trigger reference pulse width

  // ==========================================================================
  // carrier types
  typedef logic [CNT_W-1:0] bpgs_cnt_t;       // cycle count

  typedef struct packed {
    logic      bracket_enable;                // host bracket request
    logic      third_generation_filmless_intensifier; // fitted tube type
    bpgs_cnt_t gate_delay;                    // trigger to gate, cycles
    bpgs_cnt_t gate_width;                    // gate width, cycles
  } bpgs_cfg_s;

  typedef struct packed {
    logic photocathode_gate;                  // cathode bias on
    logic multiplier_plate_bias_enable;       // plate bias on
    logic trigger_reference_output;           // reference pulse
  } bpgs_drv_s;

  typedef enum logic [2:0] {
    BPGS_IDLE  = 3'b000,                      // waiting for trigger
    BPGS_DELAY = 3'b001,                      // counting gate delay
    BPGS_GATE  = 3'b010,                      // cathode gated on
    BPGS_TAIL  = 3'b011,                      // plate tail hold
    BPGS_HOLD  = 3'b100                       // repetition lockout
  } bpgs_state_e;

endpackage : bpgs_pkg

// file: tb/bpgs_sequencer_asserts.sv
// checker and bind for the bracket pulse gate sequencer
`timescale 1ns/10ps
module bpgs_sequencer_chk (
  input wire logic                clk,
  input wire logic                rst_b,
  input wire logic                clk_en,
  input wire logic                trigger_in,
  input wire bpgs_pkg::bpgs_cfg_s cfg,
  input wire bpgs_pkg::bpgs_drv_s drv,
  input wire logic                bracket_active
);
  logic [15:0] gap_reg;  // cycles since last reference rise
  logic        brk_reg;  // mode of the last shot
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  // ==========================================================================
  // spacing counter between reference pulses
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      gap_reg <= 16'hFFFF;
      brk_reg <= 1'b0;
    end else if ($rose(drv.trigger_reference_output)) begin
      gap_reg <= 16'h0000;
      brk_reg <= bracket_active;
    end else if (clk_en && gap_reg != 16'hFFFF) begin
      gap_reg <= gap_reg + 16'h0001;
    end
  end
  // ==========================================================================
  // properties
  chk_plate_plain_on: assert property (
    drv.photocathode_gate && !bracket_active
    |-> drv.multiplier_plate_bias_enable) else $error("plate off in gate");
  chk_plate_window: assert property (
    drv.photocathode_gate && bracket_active
    |-> drv.multiplier_plate_bias_enable) else $error("plate off in window");
  chk_plate_lead: assert property (
    $rose(drv.photocathode_gate) && bracket_active
    |-> $past(drv.multiplier_plate_bias_enable, 7)) else $error("short lead");
  chk_plate_early: assert property (
    $rose(drv.multiplier_plate_bias_enable) && bracket_active
    |-> ##[1:7] drv.photocathode_gate) else $error("plate on too early");
  chk_plate_tail: assert property (
    $fell(drv.photocathode_gate) && bracket_active
    |-> ##195 drv.multiplier_plate_bias_enable
    ##[1:10] !drv.multiplier_plate_bias_enable) else $error("bad tail");
  chk_tref_width: assert property (
    $rose(drv.trigger_reference_output)
    |-> drv.trigger_reference_output[*8] ##1 !drv.trigger_reference_output)
    else $error("reference width wrong");
  chk_tref_latency: assert property (
    $rose(drv.trigger_reference_output)
    |-> $past(trigger_in, 3) && !$past(trigger_in, 4))
    else $error("reference latency wrong");
  chk_min_delay: assert property (
    $rose(drv.trigger_reference_output) && bracket_active
    |-> !drv.photocathode_gate[*5]) else $error("gate too early");
  chk_film_block: assert property (
    $rose(bracket_active) |-> $past(cfg.bracket_enable)
    && !$past(cfg.third_generation_filmless_intensifier))
    else $error("bracket wrongly active");
  chk_rep_gap: assert property (
    $rose(drv.trigger_reference_output)
    |-> gap_reg >= (brk_reg ? 16'd31999 : 16'd199)) else $error("rate high");
  cov_brk: cover property ($rose(drv.photocathode_gate) && bracket_active);
  cov_plain: cover property ($rose(drv.photocathode_gate) && !bracket_active);
  cov_tref: cover property ($rose(drv.trigger_reference_output));
endmodule : bpgs_sequencer_chk
bind bpgs_sequencer bpgs_sequencer_chk u_chk (.clk(clk), .rst_b(rst_b),
  .clk_en(clk_en), .trigger_in(trigger_in), .cfg(cfg), .drv(drv),
  .bracket_active(bracket_active));

// file: tb/bpgs_trig_model.sv
// external trigger source model
`timescale 1ns/10ps
module bpgs_trig_model (
  input  wire logic clk,
  input  wire logic rst_b,
  input  wire logic fire,       // request from the bench
  output logic      trigger_in  // trigger level to the block
);
  logic [1:0] hold_reg;  // level kept high a few cycles
  // stretch the request so the edge is a clean level step
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) hold_reg <= 2'h0;
    else if (fire) hold_reg <= 2'h3;
    else if (hold_reg != 2'h0) hold_reg <= hold_reg - 2'h1;
  end
  assign trigger_in = fire | (hold_reg != 2'h0);
endmodule : bpgs_trig_model

// file: tb/testbench.sv
// self-checking bench for the bracket pulse gate sequencer
`timescale 1ns/10ps
module testbench;
  logic clk = 1'b0;
  logic rst_b, clk_en, fire, trigger_in, bracket_active, brk_seen;
  bpgs_pkg::bpgs_cfg_s cfg;
  bpgs_pkg::bpgs_drv_s drv;
  int fails = 0;
  int check_count = 0;
  int t_tr, t_on, t_off, t_pu, t_pd;  // event cycles after taking edge
  always #2.5 clk = ~clk;
  bpgs_trig_model u_src (.clk(clk), .rst_b(rst_b), .fire(fire),
    .trigger_in(trigger_in));
  bpgs_sequencer uut (.clk(clk), .rst_b(rst_b), .clk_en(clk_en),
    .trigger_in(trigger_in), .cfg(cfg), .drv(drv),
    .bracket_active(bracket_active));
  // ==========================================================================
  // shared tasks
  task automatic complete_run;
    $display("checks %0d fails %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : complete_run
  task automatic check(input string nm, input logic [31:0] seen, exp);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] %s exp %0d seen %0d", nm, exp, seen);
    end
  endtask : check
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick
  task automatic setup(input logic brk, film, input int dly, wid);
    cfg.bracket_enable = brk;
    cfg.third_generation_filmless_intensifier = film;
    cfg.gate_delay = dly[23:0];
    cfg.gate_width = wid[23:0];
  endtask : setup
  // one trigger, then watch n cycles
  task automatic shot(input int n);
    int k;
    {t_tr, t_on, t_off, t_pu, t_pd} = {5{-32'sd1}};
    brk_seen = 1'b0;
    fire = 1'b1;
    tick(1);
    fire = 1'b0;
    for (k = 1; k <= n; k++) begin
      tick(1);
      if (drv.trigger_reference_output === 1'b1 && t_tr < 0) t_tr = k;
      if (drv.photocathode_gate === 1'b1 && t_on < 0) t_on = k;
      if (drv.photocathode_gate === 1'b0 && t_on > 0 && t_off < 0) t_off = k;
      if (drv.multiplier_plate_bias_enable === 1'b1 && t_pu < 0) t_pu = k;
      if (drv.multiplier_plate_bias_enable === 1'b0 && t_off > 0 && t_pd < 0)
        t_pd = k;
      if (bracket_active === 1'b1) brk_seen = 1'b1;
    end
  endtask : shot
  // ==========================================================================
  // scenarios
  task automatic s_plain;
    setup(1'b0, 1'b0, 10, 5);
    shot(260);
    check("tref", t_tr, 2);
    check("gate_on", t_on, 10);
    check("gate_off", t_off, 15);
    check("plate_on", t_pu, 1);
    check("plate_off", t_pd, -1);
    check("bracket", brk_seen, 0);
  endtask : s_plain
  task automatic s_rep_plain;
    shot(60);
    check("tref", t_tr, 2);
    shot(60);
    check("early_shot", t_tr, -1);
    tick(100);
    shot(260);
    check("late_shot", t_tr, 2);
  endtask : s_rep_plain
  task automatic s_film;
    setup(1'b1, 1'b1, 10, 5);
    shot(260);
    check("gate_on", t_on, 10);
    check("plate_off", t_pd, -1);
    check("bracket", brk_seen, 0);
  endtask : s_film
  task automatic s_brk;
    setup(1'b1, 1'b0, 10, 5);
    shot(260);
    check("tref", t_tr, 2);
    check("gate_on", t_on, 12);
    check("plate_on", t_pu, 5);
    check("gate_off", t_off, 17);
    check("plate_off", t_pd, 218);
    check("bracket", brk_seen, 1);
  endtask : s_brk
  // short delay in bracket mode on purpose, expecting the clamp
  task automatic s_rep_brk;
    setup(1'b1, 1'b0, 2, 3);
    tick(31000);
    shot(40);
    check("early_shot", t_tr, -1);
    tick(800);
    shot(260);
    check("gate_on", t_on, 7);
    check("gate_off", t_off, 10);
    check("plate_on", t_pu, 1);
    check("plate_off", t_pd, 211);
  endtask : s_rep_brk
  // ==========================================================================
  // main sequence and watchdog
  initial begin
    rst_b = 1'b0;
    clk_en = 1'b1;
    fire = 1'b0;
    setup(1'b0, 1'b0, 10, 5);
    repeat (16) @(posedge clk);
    #1 rst_b = 1'b1;
    tick(2);
    s_plain;
    s_rep_plain;
    s_film;
    s_brk;
    s_rep_brk;
    complete_run;
  end
  initial begin
    #500000;
    fails++;
    complete_run;
  end
endmodule : testbench
